//--- shared/split_commit_pkg.sv
// constants for the split-transaction commitment register bank
package split_commit_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          ADQ_W         = 16;
    localparam logic [7:0]  OFF_UP_COMMIT = 8'h88;
    localparam logic [7:0]  OFF_DN_COMMIT = 8'h8c;
    localparam logic [7:0]  OFF_PM_CAP    = 8'h90;
    localparam logic [7:0]  OFF_SPLIT_STS = 8'h84;
    localparam logic [15:0] BUF_CAP_ADQ   = 16'h0010;
    localparam logic [15:0] LIMIT_RST     = 16'h0010;
    localparam logic [15:0] LIMIT_UNBOUND = 16'hffff;
    localparam logic [7:0]  PM_CAP_ID     = 8'h01;
    localparam logic [7:0]  NEXT_CAP_PTR  = 8'ha8;
    localparam int          CAP_LO        = 0;
    localparam int          LIM_LO        = 16;
    localparam int          ID_LO         = 0;
    localparam int          PTR_LO        = 8;
    localparam int          DLY_BIT       = 21;
    localparam logic [31:0] SLVERR_DATA   = 32'h0000_0000;

    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DN = 2'b10
    } dir_t;
endpackage : split_commit_pkg

//--- hdl/commit_gate.sv
// admission check of one direction against its commitment limit
`timescale 1ns/1ns
`default_nettype none
module commit_gate (
    input  wire logic                                clk_in,
    input  wire logic                                rstn_in,
    input  wire logic [split_commit_pkg::ADQ_W-1:0]  limit_in,
    input  wire logic                                req_valid_in,
    input  wire logic [split_commit_pkg::ADQ_W-1:0]  req_size_in,
    input  wire logic                                cpl_done_in,
    input  wire logic [split_commit_pkg::ADQ_W-1:0]  cpl_size_in,
    output logic                                     req_grant_out,
    output logic                                     req_delay_out,
    output logic [split_commit_pkg::ADQ_W-1:0]       used_out
);
    import split_commit_pkg::*;

    logic [ADQ_W:0] sum;
    logic           fits;
    logic [ADQ_W-1:0] used_nxt;

    always_comb begin
        sum  = {1'b0, used_out} + {1'b0, req_size_in};
        fits = (limit_in == LIMIT_UNBOUND) || (sum <= {1'b0, limit_in});
        used_nxt = used_out;
        if (cpl_done_in)
            used_nxt = (cpl_size_in > used_out) ? '0 : used_out - cpl_size_in;
        if (req_valid_in && fits && limit_in != LIMIT_UNBOUND)
            used_nxt = used_nxt + req_size_in;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            used_out      <= '0;
            req_grant_out <= 1'b0;
            req_delay_out <= 1'b0;
        end else begin
            used_out      <= used_nxt;
            req_grant_out <= req_valid_in && fits;
            req_delay_out <= req_valid_in && !fits;
        end
    end
endmodule : commit_gate
`default_nettype wire

//--- hdl/apb_access.sv
// apb slave handshake: one-wait-state access phase
`timescale 1ns/1ns
`default_nettype none
module apb_access (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    input  wire logic psel_in,
    input  wire logic penable_in,
    input  wire logic pwrite_in,
    output logic      pready_out,
    output logic      wr_fire_out,
    output logic      rd_fire_out
);
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in)
            pready_out <= 1'b0;
        else
            pready_out <= psel_in && penable_in && !pready_out;
    end

    always_comb begin
        wr_fire_out = psel_in && penable_in && pready_out && pwrite_in;
        rd_fire_out = psel_in && penable_in && !pready_out && !pwrite_in;
    end
endmodule : apb_access
`default_nettype wire

//--- hdl/split_transaction_commit_regs.sv
// split-transaction commitment registers with apb access
//
// Notes on behaviour
// - upstream buffer capability, bits 15:0, read-only 0010h (16 adqs)
// - upstream buffer serves secondary requesters reading primary completers
// - upstream commitment limit bits 31:16, read-write, reset 0010h
// - any value written to either limit is accepted
// - limit ffffh forwards any split request regardless of free space
// - downstream buffer capability read-only 0010h (16 adqs)
// - downstream buffer serves primary requesters reading secondary completers
// - downstream commitment limit bits 31:16, read-write, reset 0010h
// - capability id 01h in bits 7:0 at 90h, read-only
// - next-capability pointer a8h in bits 15:8, read-only
// - request over limit is delayed; sticky w1c delayed flag bit 21
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module split_transaction_commit_regs (
    input  wire logic                                 clk_in,
    input  wire logic                                 rstn_in,
    input  wire logic                                 psel_in,
    input  wire logic                                 penable_in,
    input  wire logic                                 pwrite_in,
    input  wire logic [split_commit_pkg::ADDR_W-1:0]  paddr_in,
    input  wire logic [split_commit_pkg::DATA_W-1:0]  pwdata_in,
    input  wire logic [3:0]                           pstrb_in,
    output logic [split_commit_pkg::DATA_W-1:0]       prdata_out,
    output logic                                      pready_out,
    output logic                                      pslverr_out,
    input  wire logic                                 up_req_valid_in,
    input  wire logic [split_commit_pkg::ADQ_W-1:0]   up_req_size_in,
    input  wire logic                                 up_cpl_done_in,
    input  wire logic [split_commit_pkg::ADQ_W-1:0]   up_cpl_size_in,
    input  wire logic                                 dn_req_valid_in,
    input  wire logic [split_commit_pkg::ADQ_W-1:0]   dn_req_size_in,
    input  wire logic                                 dn_cpl_done_in,
    input  wire logic [split_commit_pkg::ADQ_W-1:0]   dn_cpl_size_in,
    output logic                                      up_req_grant_out,
    output logic                                      up_req_delay_out,
    output logic                                      dn_req_grant_out,
    output logic                                      dn_req_delay_out,
    output logic                                      split_delayed_out
);
    import split_commit_pkg::*;

    logic [ADQ_W-1:0] up_limit_r;
    logic [ADQ_W-1:0] dn_limit_r;
    logic             dly_sts_r;
    logic             wr_fire;
    logic             rd_fire;
    logic             ready_i;
    logic [ADQ_W-1:0] up_used;
    logic [ADQ_W-1:0] dn_used;
    logic [DATA_W-1:0] rd_nxt;
    logic             err_nxt;
    logic             sts_clear;

    function automatic logic [ADQ_W-1:0] merge_hi(
        input logic [ADQ_W-1:0]  old,
        input logic [DATA_W-1:0] wd,
        input logic [3:0]        st
    );
        logic [ADQ_W-1:0] r;
        r = old;
        if (st[2])
            r[7:0] = wd[LIM_LO +: 8];
        if (st[3])
            r[15:8] = wd[LIM_LO+8 +: 8];
        return r;
    endfunction : merge_hi

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == OFF_UP_COMMIT || a == OFF_DN_COMMIT ||
               a == OFF_PM_CAP || a == OFF_SPLIT_STS;
    endfunction : mapped

    apb_access u_apb (
        .clk_in      (clk_in),
        .rstn_in     (rstn_in),
        .psel_in     (psel_in),
        .penable_in  (penable_in),
        .pwrite_in   (pwrite_in),
        .pready_out  (ready_i),
        .wr_fire_out (wr_fire),
        .rd_fire_out (rd_fire)
    );
    assign pready_out = ready_i;

    // secondary requester -> primary completer
    commit_gate u_up (
        .clk_in        (clk_in),
        .rstn_in       (rstn_in),
        .limit_in      (up_limit_r),
        .req_valid_in  (up_req_valid_in),
        .req_size_in   (up_req_size_in),
        .cpl_done_in   (up_cpl_done_in),
        .cpl_size_in   (up_cpl_size_in),
        .req_grant_out (up_req_grant_out),
        .req_delay_out (up_req_delay_out),
        .used_out      (up_used)
    );

    // primary requester -> secondary completer
    commit_gate u_dn (
        .clk_in        (clk_in),
        .rstn_in       (rstn_in),
        .limit_in      (dn_limit_r),
        .req_valid_in  (dn_req_valid_in),
        .req_size_in   (dn_req_size_in),
        .cpl_done_in   (dn_cpl_done_in),
        .cpl_size_in   (dn_cpl_size_in),
        .req_grant_out (dn_req_grant_out),
        .req_delay_out (dn_req_delay_out),
        .used_out      (dn_used)
    );

    // commitment limits
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            up_limit_r <= LIMIT_RST;
            dn_limit_r <= LIMIT_RST;
        end else if (wr_fire) begin
            if (paddr_in == OFF_UP_COMMIT)
                up_limit_r <= merge_hi(up_limit_r, pwdata_in, pstrb_in);
            if (paddr_in == OFF_DN_COMMIT)
                dn_limit_r <= merge_hi(dn_limit_r, pwdata_in, pstrb_in);
        end
    end

    // sticky delayed flag, set beats clear
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in)
            dly_sts_r <= 1'b0;
        else if (up_req_delay_out || dn_req_delay_out)
            dly_sts_r <= 1'b1;
        else if (wr_fire && paddr_in == OFF_SPLIT_STS && pstrb_in[2] &&
                 pwdata_in[DLY_BIT])
            dly_sts_r <= 1'b0;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in)
            split_delayed_out <= 1'b0;
        else
            split_delayed_out <= dly_sts_r;
    end

    // read mux; fixed fields come from constants only
    always_comb begin
        rd_nxt = '0;
        case (paddr_in)
            OFF_UP_COMMIT: begin
                rd_nxt[CAP_LO +: ADQ_W] = BUF_CAP_ADQ;
                rd_nxt[LIM_LO +: ADQ_W] = up_limit_r;
            end
            OFF_DN_COMMIT: begin
                rd_nxt[CAP_LO +: ADQ_W] = BUF_CAP_ADQ;
                rd_nxt[LIM_LO +: ADQ_W] = dn_limit_r;
            end
            OFF_PM_CAP: begin
                rd_nxt[ID_LO +: 8]  = PM_CAP_ID;
                rd_nxt[PTR_LO +: 8] = NEXT_CAP_PTR;
            end
            OFF_SPLIT_STS: rd_nxt[DLY_BIT] = dly_sts_r;
            default: rd_nxt = SLVERR_DATA;
        endcase
        err_nxt = !mapped(paddr_in);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_out  <= '0;
            pslverr_out <= 1'b0;
        end else begin
            if (rd_fire)
                prdata_out <= rd_nxt;
            pslverr_out <= psel_in && penable_in && !ready_i && err_nxt;
        end
    end

    // assertions
    a_up_limit_reset: assert property (@(posedge clk_in)
        $rose(rstn_in) |-> up_limit_r == LIMIT_RST)
        else $error("upstream limit not at reset value");
    a_dn_limit_reset: assert property (@(posedge clk_in)
        $rose(rstn_in) |-> dn_limit_r == LIMIT_RST)
        else $error("downstream limit not at reset value");
    a_limit_write_takes: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        wr_fire && paddr_in == OFF_UP_COMMIT && (&pstrb_in[3:2]) |=>
        up_limit_r == $past(pwdata_in[31:16]))
        else $error("upstream limit write lost");
    a_up_cap_read: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        rd_fire && paddr_in == OFF_UP_COMMIT |=>
        prdata_out[15:0] == BUF_CAP_ADQ)
        else $error("upstream capability wrong");
    a_dn_cap_read: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        rd_fire && paddr_in == OFF_DN_COMMIT |=>
        prdata_out[15:0] == BUF_CAP_ADQ)
        else $error("downstream capability wrong");
    a_cap_id_read: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        rd_fire && paddr_in == OFF_PM_CAP |=> prdata_out[7:0] == PM_CAP_ID)
        else $error("capability id wrong");
    a_next_ptr_read: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        rd_fire && paddr_in == OFF_PM_CAP |=>
        prdata_out[15:8] == NEXT_CAP_PTR)
        else $error("next pointer wrong");
    a_unbound_grants: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        up_req_valid_in && up_limit_r == LIMIT_UNBOUND |=>
        up_req_grant_out && !up_req_delay_out)
        else $error("unbounded limit delayed a request");
    sequence delay_seen;
        up_req_delay_out || dn_req_delay_out;
    endsequence
    a_delay_sticky: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        delay_seen |=> dly_sts_r ##1 split_delayed_out)
        else $error("delayed flag not set");
    a_over_limit_delay: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        dn_req_valid_in && dn_limit_r != LIMIT_UNBOUND &&
        ({1'b0, dn_used} + {1'b0, dn_req_size_in}) > {1'b0, dn_limit_r}
        |=> dn_req_delay_out && !dn_req_grant_out)
        else $error("over-limit request not delayed");
    assign sts_clear = wr_fire && paddr_in == OFF_SPLIT_STS && pstrb_in[2] &&
                       pwdata_in[DLY_BIT];
    a_dn_limit_write: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        wr_fire && paddr_in == OFF_DN_COMMIT && (&pstrb_in[3:2]) |=>
        dn_limit_r == $past(pwdata_in[LIM_LO +: ADQ_W]))
        else $error("downstream limit write lost");
    a_up_low_lane: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        wr_fire && paddr_in == OFF_UP_COMMIT && pstrb_in[2] && !pstrb_in[3]
        |=> up_limit_r[7:0] == $past(pwdata_in[LIM_LO +: 8]) &&
        up_limit_r[15:8] == $past(up_limit_r[15:8]))
        else $error("upstream limit lane merge wrong");
    a_up_limit_hold: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        !(wr_fire && paddr_in == OFF_UP_COMMIT) |=> $stable(up_limit_r))
        else $error("upstream limit changed without a write");
    a_dn_limit_hold: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        !(wr_fire && paddr_in == OFF_DN_COMMIT) |=> $stable(dn_limit_r))
        else $error("downstream limit changed without a write");
    a_up_limit_read: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        rd_fire && paddr_in == OFF_UP_COMMIT |=>
        prdata_out[LIM_LO +: ADQ_W] == $past(up_limit_r))
        else $error("upstream limit read back wrong");
    a_dn_limit_read: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        rd_fire && paddr_in == OFF_DN_COMMIT |=>
        prdata_out[LIM_LO +: ADQ_W] == $past(dn_limit_r))
        else $error("downstream limit read back wrong");
    a_sts_read: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        rd_fire && paddr_in == OFF_SPLIT_STS |=>
        prdata_out[DLY_BIT] == $past(dly_sts_r))
        else $error("delayed flag read back wrong");
    a_dn_unbound_grants: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        dn_req_valid_in && dn_limit_r == LIMIT_UNBOUND |=>
        dn_req_grant_out && !dn_req_delay_out)
        else $error("unbounded downstream limit delayed a request");
    a_up_no_accum: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        up_limit_r == LIMIT_UNBOUND && !up_cpl_done_in |=>
        up_used == $past(up_used))
        else $error("unbounded upstream limit took buffer space");
    a_dn_no_accum: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        dn_limit_r == LIMIT_UNBOUND && !dn_cpl_done_in |=>
        dn_used == $past(dn_used))
        else $error("unbounded downstream limit took buffer space");
    sequence up_over;
        up_req_valid_in && up_limit_r != LIMIT_UNBOUND &&
        ({1'b0, up_used} + {1'b0, up_req_size_in}) > {1'b0, up_limit_r};
    endsequence
    a_up_over_delay: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        up_over |=> up_req_delay_out && !up_req_grant_out)
        else $error("upstream over-limit request not delayed");
    sequence up_fits;
        up_req_valid_in &&
        ({1'b0, up_used} + {1'b0, up_req_size_in}) <= {1'b0, up_limit_r};
    endsequence
    a_up_fit_grant: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        up_fits |=> up_req_grant_out && !up_req_delay_out)
        else $error("upstream request within limit delayed");
    sequence dn_fits;
        dn_req_valid_in &&
        ({1'b0, dn_used} + {1'b0, dn_req_size_in}) <= {1'b0, dn_limit_r};
    endsequence
    a_dn_fit_grant: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        dn_fits |=> dn_req_grant_out && !dn_req_delay_out)
        else $error("downstream request within limit delayed");
    a_up_idle_quiet: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        !up_req_valid_in |=> !up_req_grant_out && !up_req_delay_out)
        else $error("upstream answer without a request");
    a_dn_idle_quiet: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        !dn_req_valid_in |=> !dn_req_grant_out && !dn_req_delay_out)
        else $error("downstream answer without a request");
    a_up_grant_takes: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        up_fits ##0 (up_limit_r != LIMIT_UNBOUND && !up_cpl_done_in) |=>
        up_used == $past(up_used) + $past(up_req_size_in))
        else $error("upstream grant did not take buffer space");
    a_dn_grant_takes: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        dn_fits ##0 (dn_limit_r != LIMIT_UNBOUND && !dn_cpl_done_in) |=>
        dn_used == $past(dn_used) + $past(dn_req_size_in))
        else $error("downstream grant did not take buffer space");
    a_flag_clear: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        sts_clear && !up_req_delay_out && !dn_req_delay_out |=> !dly_sts_r)
        else $error("delayed flag not cleared");
    a_set_beats_clear: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        sts_clear ##0 delay_seen |=> dly_sts_r)
        else $error("clear won over a new delay");
    a_flag_holds: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        dly_sts_r && !sts_clear |=> dly_sts_r)
        else $error("delayed flag dropped without a clear");
    a_flag_no_set: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        !dly_sts_r && !up_req_delay_out && !dn_req_delay_out |=> !dly_sts_r)
        else $error("delayed flag set without a delay");
    sequence flag_cleared;
        (sts_clear && !up_req_delay_out && !dn_req_delay_out) ##1
        (!up_req_delay_out && !dn_req_delay_out);
    endsequence
    a_clear_reaches_pin: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        flag_cleared |=> !split_delayed_out)
        else $error("delayed pin still high after clear");
    sequence setup_access;
        (psel_in && !penable_in) ##1 (psel_in && penable_in);
    endsequence
    a_ready_one_wait: assert property (@(posedge clk_in)
        disable iff (!rstn_in)
        setup_access |=> pready_out ##1 !pready_out)
        else $error("access phase not answered after one wait");
endmodule : split_transaction_commit_regs
`default_nettype wire

//--- sim/test_split_transaction_commit_regs.sv
// self-checking bench for the split commitment register bank
`timescale 1ns/1ns
`default_nettype none
module test_split_transaction_commit_regs;
    import split_commit_pkg::*;
    logic        clk_in;
    logic        rstn_in;
    logic        psel_in;
    logic        penable_in;
    logic        pwrite_in;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in;
    logic [3:0]  pstrb_in;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        up_v, dn_v, up_c, dn_c;
    logic [15:0] up_s, dn_s, up_cs, dn_cs;
    logic        up_g, up_d, dn_g, dn_d;
    logic        split_delayed_out;
    logic [31:0] rd;
    logic        err;
    int          error_cnt;
    int          n_compared;

    split_transaction_commit_regs uut (
        .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .up_req_valid_in(up_v),
        .up_req_size_in(up_s), .up_cpl_done_in(up_c),
        .up_cpl_size_in(up_cs), .dn_req_valid_in(dn_v),
        .dn_req_size_in(dn_s), .dn_cpl_done_in(dn_c),
        .dn_cpl_size_in(dn_cs), .up_req_grant_out(up_g),
        .up_req_delay_out(up_d), .dn_req_grant_out(dn_g),
        .dn_req_delay_out(dn_d), .split_delayed_out(split_delayed_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic do_reset;
        rstn_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk({31'h0, pready_out}, 32'h0);
        rstn_in <= 1'b1;
    endtask : do_reset

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] st);
        int n;
        @(posedge clk_in);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= w;
        paddr_in   <= a;
        pwdata_in  <= d;
        pstrb_in   <= st;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        rd  = prdata_out;
        err = pslverr_out;
        if (n >= 50) chk(32'h0, 32'h1);
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rd & m, e);
        chk({31'h0, err}, 32'h0);
    endtask : rchk

    // one request; grant or delay shows one cycle later
    task automatic req(input logic dn, input logic [15:0] s,
                       input logic g);
        @(posedge clk_in);
        if (dn) begin
            dn_v <= 1'b1;
            dn_s <= s;
        end else begin
            up_v <= 1'b1;
            up_s <= s;
        end
        @(posedge clk_in);
        dn_v <= 1'b0;
        up_v <= 1'b0;
        #1;
        if (dn) chk({dn_g, dn_d}, {g, ~g});
        else chk({up_g, up_d}, {g, ~g});
    endtask : req

    task automatic cpl(input logic dn, input logic [15:0] s);
        @(posedge clk_in);
        if (dn) begin
            dn_c  <= 1'b1;
            dn_cs <= s;
        end else begin
            up_c  <= 1'b1;
            up_cs <= s;
        end
        @(posedge clk_in);
        dn_c <= 1'b0;
        up_c <= 1'b0;
    endtask : cpl

    initial begin
        #200000;
        chk(32'h0, 32'h1);
        finish_test();
    end

    initial begin
        error_cnt = 0;
        n_compared = 0;
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        pstrb_in = 4'h0;
        {up_v, dn_v, up_c, dn_c, up_s, dn_s, up_cs, dn_cs} = '0;
        rstn_in = 1'b0;
        do_reset();
        rchk(OFF_UP_COMMIT, 32'hffff_ffff, 32'h0010_0010);
        rchk(OFF_DN_COMMIT, 32'hffff_ffff, 32'h0010_0010);
        rchk(OFF_PM_CAP, 32'h0000_ffff, 32'h0000_a801);
        apb(1'b1, OFF_PM_CAP, 32'h0, 4'hf);
        rchk(OFF_PM_CAP, 32'h0000_ffff, 32'h0000_a801);
        // default limit admits exactly the whole buffer
        req(1'b0, 16'h0010, 1'b1);
        req(1'b0, 16'h0001, 1'b0);
        cpl(1'b0, 16'h0010);
        // any value, and only the upper lanes land
        apb(1'b1, OFF_DN_COMMIT, 32'h0005_1234, 4'hf);
        rchk(OFF_DN_COMMIT, 32'hffff_ffff, 32'h0005_0010);
        apb(1'b1, OFF_DN_COMMIT, 32'h0007_0000, 4'h1);
        rchk(OFF_DN_COMMIT, 32'hffff_ffff, 32'h0005_0010);
        apb(1'b1, OFF_SPLIT_STS, 32'h0020_0000, 4'h4);
        req(1'b1, 16'h0003, 1'b1);
        req(1'b1, 16'h0003, 1'b0);
        repeat (2) @(posedge clk_in);
        #1;
        chk({31'h0, split_delayed_out}, 32'h1);
        rchk(OFF_SPLIT_STS, 32'h0020_0000, 32'h0020_0000);
        rchk(OFF_SPLIT_STS, 32'h0020_0000, 32'h0020_0000);
        cpl(1'b1, 16'h0003);
        req(1'b1, 16'h0005, 1'b1);
        req(1'b1, 16'h0001, 1'b0);
        cpl(1'b1, 16'h0005);
        apb(1'b1, OFF_SPLIT_STS, 32'h0020_0000, 4'h4);
        rchk(OFF_SPLIT_STS, 32'h0020_0000, 32'h0);
        chk({31'h0, split_delayed_out}, 32'h0);
        // unbounded limit forwards anything, repeatedly
        apb(1'b1, OFF_UP_COMMIT, 32'hffff_ffff, 4'hf);
        rchk(OFF_UP_COMMIT, 32'hffff_ffff, 32'hffff_0010);
        req(1'b0, 16'hffff, 1'b1);
        req(1'b0, 16'hffff, 1'b1);
        apb(1'b1, OFF_DN_COMMIT, 32'hffff_0000, 4'hc);
        req(1'b1, 16'h8000, 1'b1);
        req(1'b1, 16'h8000, 1'b1);
        // unmapped place answers with an error and zero data
        apb(1'b0, 8'h00, 32'h0, 4'h0);
        chk({rd[31:1], err}, 32'h1);
        // second reset restores the limits
        @(posedge clk_in);
        do_reset();
        rchk(OFF_UP_COMMIT, 32'hffff_ffff, 32'h0010_0010);
        rchk(OFF_DN_COMMIT, 32'hffff_ffff, 32'h0010_0010);
        finish_test();
    end
endmodule : test_split_transaction_commit_regs
`default_nettype wire
